/* core/sbt_timer.v */
// 16-bit timer/counter with capture and three compare outputs
//
// Functional notes
// - with filter on, capture input changes only after four equal samples.
// - edge select zero means falling edge, one means rising edge.
// - capture copies counter into capture register and sets event flag.
// - modes using capture register as maximum disconnect the capture pin.
// - control b bit 5 reads zero and ignores writes.
// - control b bits 4:3 are the upper two waveform mode bits.
// - mode 0 normal, 1-3 phase-correct, 5-7 fast, 8/9/10-bit maxima.
// - modes 4 and C clear on compare a match; mode D reserved.
// - modes 8/9 phase-frequency correct, A/B phase correct, capture or cmp a.
// - mode E fast with capture maximum, mode F fast with compare a maximum.
// - clock select 0 stops; 1-5 divide i/o clock by 1,8,64,256,1024.
// - clock select 6 counts falling, 7 rising edges of external pin.
// - external pin counts even while driven as an output.
// - force bit in non-pwm mode applies compare action now; pwm ignores it.
// - forced match raises no interrupt and never clears the counter.
// - force bits are strobes reading zero; control c low bits reserved.
// - counter is two byte locations accessed through the shared latch.
// - counter write blocks compare matches on the next timer tick.
// - compare a is checked every tick; match pulses and drives output a.
// - compare a high and low bytes update together through the latch.
// - non-pwm output mode 0 off, 1 toggle, 2 clear, 3 set.
// - capture interrupt needs flag, capture enable and global enable.
`timescale 1ns/100ps
`default_nettype none
`include "sbt_timer_regs.vh"

module sbt_timer (
  input  wire        mclk,
  input  wire        rst,
  input  wire [7:0]  io_addr,
  input  wire [7:0]  io_wdata,
  input  wire        io_we,
  input  wire        io_re,
  output reg  [7:0]  io_rdata_r,
  input  wire [1:0]  waveform_mode_low,
  input  wire [1:0]  compare_output_mode_a,
  input  wire [1:0]  compare_output_mode_b,
  input  wire [1:0]  compare_output_mode_c,
  input  wire [15:0] compare_value_b,
  input  wire [15:0] compare_value_c,
  input  wire        capture_interrupt_enable,
  input  wire        global_irq_enable,
  input  wire        capture_flag_clear,
  input  wire        capture_input_pin,
  input  wire        external_count_pin,
  output reg  [15:0] capture_value_r,
  output reg         capture_event_flag_r,
  output reg         capture_irq_r,
  output reg         compare_a_match_r,
  output wire        compare_output_a,
  output wire        compare_output_b,
  output wire        compare_output_c,
  output wire        compare_output_a_en,
  output wire        compare_output_b_en,
  output wire        compare_output_c_en
);

  // -------------------------------------------------------------
  // mode decode helpers
  // -------------------------------------------------------------
  // mode class: 0 normal/ctc, 1 fast pwm, 2 phase or phase-freq
  function [1:0] mode_class;
    input [3:0] m;
    begin
      case (m)
        4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_class = 2'h1;
        4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
        4'hA, 4'hB:                   mode_class = 2'h2;
        default:                      mode_class = 2'h0;
      endcase
    end
  endfunction

  function [15:0] mode_top;
    input [3:0]  m;
    input [15:0] icr;
    input [15:0] ocra;
    begin
      case (m)
        4'h1, 4'h5: mode_top = `SBT_TOP_8BIT;
        4'h2, 4'h6: mode_top = `SBT_TOP_9BIT;
        4'h3, 4'h7: mode_top = `SBT_TOP_10BIT;
        4'h4, 4'h9, 4'hB, 4'hC, 4'hF:
                    mode_top = ocra;
        4'h8, 4'hA, 4'hE:
                    mode_top = icr;
        default:    mode_top = `SBT_TOP_FULL;
      endcase
    end
  endfunction

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  reg  [7:0]  ctrl_b_r;
  reg  [7:0]  latch_r;
  reg  [15:0] cnt_r;
  reg  [15:0] cmpa_r;
  reg         up_r;
  reg         block_r;
  reg         cap_prev_r;
  reg         ext_prev_r;

  wire        cap_level;
  wire        ext_level;
  wire        tick_div8;
  wire        tick_div64;
  wire        tick_div256;
  wire        tick_div1024;

  wire [3:0]  wave_mode = {ctrl_b_r[`SBT_B_WAVE_HI:`SBT_B_WAVE_LO],
                           waveform_mode_low};
  wire [2:0]  clk_sel   = ctrl_b_r[`SBT_B_CLK_HI:`SBT_B_CLK_LO];
  wire [1:0]  mclass    = mode_class(wave_mode);
  wire        non_pwm   = (mclass == 2'h0);
  wire [15:0] top_val   = mode_top(wave_mode, capture_value_r, cmpa_r);
  wire        ctc_mode  = (wave_mode == 4'h4) || (wave_mode == 4'hC);

  wire wr_b     = io_we && (io_addr == `SBT_OFS_CTRL_B);
  wire wr_c     = io_we && (io_addr == `SBT_OFS_CTRL_C);
  wire wr_cnt_l = io_we && (io_addr == `SBT_OFS_CNT_LOW);
  wire wr_cmp_l = io_we && (io_addr == `SBT_OFS_CMPA_LOW);
  wire wr_high  = io_we && ((io_addr == `SBT_OFS_CNT_HIGH) ||
                            (io_addr == `SBT_OFS_CMPA_HIGH));

  // -------------------------------------------------------------
  // input conditioning and prescaler
  // -------------------------------------------------------------
  sbt_pin_filter u_cap_filter (
    .mclk      (mclk),
    .rst       (rst),
    .pin       (capture_input_pin),
    .filter_en (ctrl_b_r[`SBT_B_FILTER_BIT]),
    .level_r   (cap_level)
  );

  // the pin is sampled whatever its port direction, so software
  // driving it as an output still clocks the counter
  sbt_pin_filter u_ext_sync (
    .mclk      (mclk),
    .rst       (rst),
    .pin       (external_count_pin),
    .filter_en (1'b0),
    .level_r   (ext_level)
  );

  sbt_prescaler u_prescaler (
    .mclk         (mclk),
    .rst          (rst),
    .tick_div8    (tick_div8),
    .tick_div64   (tick_div64),
    .tick_div256  (tick_div256),
    .tick_div1024 (tick_div1024)
  );

  // -------------------------------------------------------------
  // timer tick selection
  // -------------------------------------------------------------
  reg tick;
  always @* begin
    case (clk_sel)
      `SBT_CS_STOP:     tick = 1'b0;
      `SBT_CS_DIV1:     tick = 1'b1;
      `SBT_CS_DIV8:     tick = tick_div8;
      `SBT_CS_DIV64:    tick = tick_div64;
      `SBT_CS_DIV256:   tick = tick_div256;
      `SBT_CS_DIV1024:  tick = tick_div1024;
      `SBT_CS_EXT_FALL: tick = ext_prev_r && !ext_level;
      default:          tick = !ext_prev_r && ext_level;
    endcase
  end

  // -------------------------------------------------------------
  // compare matches: evaluated on the tick, blocked after a write
  // -------------------------------------------------------------
  wire match_a = tick && !block_r && (cnt_r == cmpa_r);
  wire match_b = tick && !block_r && (cnt_r == compare_value_b);
  wire match_c = tick && !block_r && (cnt_r == compare_value_c);
  wire at_top  = (cnt_r == top_val);
  wire wrap    = tick && at_top && (mclass != 2'h2);

  // forced matches only act in non-pwm modes
  wire force_a = wr_c && io_wdata[`SBT_C_FORCE_A_BIT] && non_pwm;
  wire force_b = wr_c && io_wdata[`SBT_C_FORCE_B_BIT] && non_pwm;
  wire force_c = wr_c && io_wdata[`SBT_C_FORCE_C_BIT] && non_pwm;

  // -------------------------------------------------------------
  // control b register
  // -------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst)
      ctrl_b_r <= `SBT_RST_CTRL_B;
    else if (wr_b)
      ctrl_b_r <= io_wdata & `SBT_B_WRITE_MASK;
  end

  // -------------------------------------------------------------
  // counter, direction and match blocking
  // -------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r   <= `SBT_RST_WORD;
      up_r    <= 1'b1;
      block_r <= 1'b0;
    end else if (wr_cnt_l) begin
      cnt_r   <= {latch_r, io_wdata};
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
      // forced matches never reach this path, so they cannot clear
      if (mclass != 2'h2) begin
        if (at_top)
          cnt_r <= `SBT_RST_WORD;
        else
          cnt_r <= cnt_r + 16'h0001;
      end else if (up_r) begin
        if (cnt_r >= top_val) begin
          up_r  <= 1'b0;
          cnt_r <= cnt_r - 16'h0001;
        end else
          cnt_r <= cnt_r + 16'h0001;
      end else begin
        if (cnt_r == `SBT_RST_WORD) begin
          up_r  <= 1'b1;
          cnt_r <= cnt_r + 16'h0001;
        end else
          cnt_r <= cnt_r - 16'h0001;
      end
    end
  end

  // -------------------------------------------------------------
  // compare value a and the shared high-byte latch
  // -------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmpa_r  <= `SBT_RST_WORD;
      latch_r <= 8'h00;
    end else begin
      if (wr_cmp_l)
        cmpa_r <= {latch_r, io_wdata};
      if (wr_high)
        latch_r <= io_wdata;
      else if (io_re && io_addr == `SBT_OFS_CNT_LOW)
        latch_r <= cnt_r[15:8];
      else if (io_re && io_addr == `SBT_OFS_CMPA_LOW)
        latch_r <= cmpa_r[15:8];
    end
  end

  // -------------------------------------------------------------
  // read data, registered one cycle after the strobe
  // -------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst)
      io_rdata_r <= 8'h00;
    else if (io_re) begin
      case (io_addr)
        `SBT_OFS_CTRL_B:    io_rdata_r <= ctrl_b_r;
        `SBT_OFS_CTRL_C:    io_rdata_r <= 8'h00;
        `SBT_OFS_CNT_LOW:   io_rdata_r <= cnt_r[7:0];
        `SBT_OFS_CMPA_LOW:  io_rdata_r <= cmpa_r[7:0];
        `SBT_OFS_CNT_HIGH:  io_rdata_r <= latch_r;
        `SBT_OFS_CMPA_HIGH: io_rdata_r <= latch_r;
        default:            io_rdata_r <= 8'h00;
      endcase
    end
  end

  // -------------------------------------------------------------
  // input capture
  // -------------------------------------------------------------
  // capture is cut off while its register serves as the maximum
  wire cap_enabled = !((wave_mode == 4'h8) || (wave_mode == 4'hA) ||
                       (wave_mode == 4'hE));
  wire cap_edge    = ctrl_b_r[`SBT_B_EDGE_BIT] ?
                     (!cap_prev_r && cap_level) :
                     (cap_prev_r && !cap_level);
  wire cap_trig    = cap_enabled && cap_edge;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cap_prev_r           <= 1'b0;
      ext_prev_r           <= 1'b0;
      capture_value_r      <= `SBT_RST_WORD;
      capture_event_flag_r <= 1'b0;
      capture_irq_r        <= 1'b0;
      compare_a_match_r    <= 1'b0;
    end else begin
      cap_prev_r <= cap_level;
      ext_prev_r <= ext_level;
      if (cap_trig) begin
        capture_value_r      <= cnt_r;
        capture_event_flag_r <= 1'b1;
      end else if (capture_flag_clear)
        capture_event_flag_r <= 1'b0;
      capture_irq_r <= capture_event_flag_r && capture_interrupt_enable &&
                       global_irq_enable;
      compare_a_match_r <= match_a;
    end
  end

  // -------------------------------------------------------------
  // waveform outputs, one generator per channel
  // -------------------------------------------------------------
  wire [2:0] ch_match = {match_c, match_b, match_a};
  wire [2:0] ch_force = {force_c, force_b, force_a};
  wire [5:0] ch_com   = {compare_output_mode_c, compare_output_mode_b,
                         compare_output_mode_a};
  wire [2:0] ch_out;
  wire [2:0] ch_en;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_chan
      reg        out_r;
      reg        en_r;
      wire [1:0] com = ch_com[2*g+1:2*g];

      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          out_r <= 1'b0;
          en_r  <= 1'b0;
        end else begin
          // mode 1 has no pwm meaning here, so the pin is released
          en_r <= (com != 2'h0) && (non_pwm || com != 2'h1);
          if (non_pwm) begin
            if (ch_match[g] || ch_force[g]) begin
              case (com)
                2'h1:    out_r <= !out_r;
                2'h2:    out_r <= 1'b0;
                2'h3:    out_r <= 1'b1;
                default: out_r <= out_r;
              endcase
            end
          end else if (mclass == 2'h1) begin
            if (wrap)
              out_r <= (com == 2'h2);
            else if (ch_match[g])
              out_r <= (com == 2'h3);
          end else if (ch_match[g]) begin
            out_r <= up_r ? (com == 2'h3) : (com == 2'h2);
          end
        end
      end

      assign ch_out[g] = out_r;
      assign ch_en[g]  = en_r;
    end
  endgenerate

  assign compare_output_a    = ch_out[0];
  assign compare_output_b    = ch_out[1];
  assign compare_output_c    = ch_out[2];
  assign compare_output_a_en = ch_en[0];
  assign compare_output_b_en = ch_en[1];
  assign compare_output_c_en = ch_en[2];

endmodule
`default_nettype wire

/* common/sbt_timer_regs.vh */
// register offsets, field positions, reset values and timing counts
`ifndef SBT_TIMER_REGS_VH
`define SBT_TIMER_REGS_VH

// ---------------------------------------------------------------
// register offsets on the byte-wide i/o port
// ---------------------------------------------------------------
`define SBT_OFS_CTRL_B      8'h91
`define SBT_OFS_CTRL_C      8'h92
`define SBT_OFS_CNT_LOW     8'h94
`define SBT_OFS_CNT_HIGH    8'h95
`define SBT_OFS_CMPA_LOW    8'h98
`define SBT_OFS_CMPA_HIGH   8'h99

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SBT_RST_CTRL_B      8'h00
`define SBT_RST_CTRL_C      8'h00
`define SBT_RST_WORD        16'h0000

// ---------------------------------------------------------------
// field positions in control b and control c
// ---------------------------------------------------------------
`define SBT_B_FILTER_BIT    7
`define SBT_B_EDGE_BIT      6
`define SBT_B_RSVD_BIT      5
`define SBT_B_WAVE_HI       4
`define SBT_B_WAVE_LO       3
`define SBT_B_CLK_HI        2
`define SBT_B_CLK_LO        0
`define SBT_B_WRITE_MASK    8'hDF
`define SBT_C_FORCE_A_BIT   7
`define SBT_C_FORCE_B_BIT   6
`define SBT_C_FORCE_C_BIT   5

// ---------------------------------------------------------------
// clock source select codes
// ---------------------------------------------------------------
`define SBT_CS_STOP         3'h0
`define SBT_CS_DIV1         3'h1
`define SBT_CS_DIV8         3'h2
`define SBT_CS_DIV64        3'h3
`define SBT_CS_DIV256       3'h4
`define SBT_CS_DIV1024      3'h5
`define SBT_CS_EXT_FALL     3'h6
`define SBT_CS_EXT_RISE     3'h7

// ---------------------------------------------------------------
// timing: prescaler width and filter length in samples
// ---------------------------------------------------------------
`define SBT_PRESCALE_BITS   10
`define SBT_FILTER_SAMPLES  4

// ---------------------------------------------------------------
// fixed maxima for the 8-, 9- and 10-bit modes and the full 16-bit range
// ---------------------------------------------------------------
`define SBT_TOP_8BIT        16'h00FF
`define SBT_TOP_9BIT        16'h01FF
`define SBT_TOP_10BIT       16'h03FF
`define SBT_TOP_FULL        16'hFFFF

`endif

/* core/sbt_pin_filter.v */
// pin synchroniser with optional four-sample filter
`timescale 1ns/100ps
`default_nettype none
`include "sbt_timer_regs.vh"

module sbt_pin_filter (
  input  wire mclk,
  input  wire rst,
  input  wire pin,
  input  wire filter_en,
  output reg  level_r
);

  reg                            sync1_r;
  reg                            sync2_r;
  reg                            sync3_r;
  reg                            stable_r;
  reg [`SBT_FILTER_SAMPLES-1:0]  hist_r;

  // -------------------------------------------------------------
  // three-stage synchroniser; a change counts once stages 2 and 3 agree
  // -------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_r  <= 1'b0;
      sync2_r  <= 1'b0;
      sync3_r  <= 1'b0;
      stable_r <= 1'b0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r)
        stable_r <= sync3_r;
    end
  end

  // -------------------------------------------------------------
  // filter: output follows only after four equal samples
  // -------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      hist_r  <= {`SBT_FILTER_SAMPLES{1'b0}};
      level_r <= 1'b0;
    end else begin
      hist_r <= {hist_r[`SBT_FILTER_SAMPLES-2:0], stable_r};
      if (!filter_en)
        level_r <= stable_r;
      else if (&hist_r)
        level_r <= 1'b1;
      else if (~|hist_r)
        level_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* core/sbt_prescaler.v */
// free-running prescaler giving one-cycle tick enables
`timescale 1ns/100ps
`default_nettype none
`include "sbt_timer_regs.vh"

module sbt_prescaler (
  input  wire mclk,
  input  wire rst,
  output wire tick_div8,
  output wire tick_div64,
  output wire tick_div256,
  output wire tick_div1024
);

  reg [`SBT_PRESCALE_BITS-1:0] div_r;

  // -------------------------------------------------------------
  // one counter shared by all ratios keeps the taps in phase
  // -------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst)
      div_r <= {`SBT_PRESCALE_BITS{1'b0}};
    else
      div_r <= div_r + 1'b1;
  end

  // each tap fires when its low bits are all ones
  assign tick_div8    = &div_r[2:0];
  assign tick_div64   = &div_r[5:0];
  assign tick_div256  = &div_r[7:0];
  assign tick_div1024 = &div_r[9:0];

endmodule
`default_nettype wire

/* verification/sbt_timer_sva.sv */
// assertion checker for the 16-bit timer block
`timescale 1ns/100ps
`default_nettype none
`include "sbt_timer_regs.vh"

module sbt_timer_sva (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [7:0]  io_addr,
  input wire logic        io_re,
  input wire logic [7:0]  io_rdata_r,
  input wire logic [1:0]  compare_output_mode_a,
  input wire logic        capture_interrupt_enable,
  input wire logic        global_irq_enable,
  input wire logic        capture_flag_clear,
  input wire logic [15:0] capture_value_r,
  input wire logic        capture_event_flag_r,
  input wire logic        capture_irq_r,
  input wire logic        compare_output_a_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // a read request at one byte address
  sequence s_rd(a);
    io_re && io_addr == a;
  endsequence
  // pending capture with both enables up
  sequence s_cause;
    capture_event_flag_r && capture_interrupt_enable && global_irq_enable;
  endsequence
  property p_rd_c; s_rd(`SBT_OFS_CTRL_C) |=> io_rdata_r == 8'h00; endproperty
  property p_rsvd; s_rd(`SBT_OFS_CTRL_B) |=> !io_rdata_r[5]; endproperty
  property p_hold; !io_re |=> $stable(io_rdata_r); endproperty
  property p_irq_set; s_cause |=> capture_irq_r; endproperty
  property p_irq_need;
    capture_irq_r |-> $past(capture_event_flag_r && capture_interrupt_enable
                            && global_irq_enable);
  endproperty
  property p_flag; capture_event_flag_r && !capture_flag_clear |=>
    capture_event_flag_r; endproperty
  property p_capv; $changed(capture_value_r) |-> capture_event_flag_r;
  endproperty
  // latency of the enable flop is covered by the third sample
  property p_en_off;
    (compare_output_mode_a == 2'h0)[*3] |-> !compare_output_a_en;
  endproperty
  a_rd_c: assert property (p_rd_c)
    else $error("control c read not zero");
  a_rsvd: assert property (p_rsvd)
    else $error("reserved control b bit read as one");
  a_hold: assert property (p_hold)
    else $error("read data moved without a read");
  a_irq_set: assert property (p_irq_set)
    else $error("capture request missing");
  a_irq_need: assert property (p_irq_need)
    else $error("capture request without cause");
  a_flag: assert property (p_flag)
    else $error("capture flag dropped without clear");
  a_capv: assert property (p_capv)
    else $error("capture value moved without event");
  a_en_off: assert property (p_en_off)
    else $error("output a driven with output mode off");
endmodule

bind sbt_timer sbt_timer_sva chk_u (.mclk(mclk), .rst(rst),
  .io_addr(io_addr), .io_re(io_re), .io_rdata_r(io_rdata_r),
  .compare_output_mode_a(compare_output_mode_a),
  .capture_interrupt_enable(capture_interrupt_enable),
  .global_irq_enable(global_irq_enable),
  .capture_flag_clear(capture_flag_clear),
  .capture_value_r(capture_value_r),
  .capture_event_flag_r(capture_event_flag_r),
  .capture_irq_r(capture_irq_r),
  .compare_output_a_en(compare_output_a_en));
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the 16-bit timer block
`timescale 1ns/100ps
`default_nettype none
`include "sbt_timer_regs.vh"

module tb_top;
  logic        mclk, rst, io_we, io_re, cie, gie, fclr, cpin, epin;
  logic [7:0]  io_addr, io_wdata, b;
  logic [1:0]  wlow, coma, comb, comc;
  logic [15:0] cmpb, cmpc, v, r;
  logic [2:0]  o;
  wire  [7:0]  rdata;
  wire  [15:0] capv;
  wire         flag, irq, mta, oa, ob, oc, oae, obe, oce;
  integer      failures, checked, cyc, seed, nmatch, ntog, i, j, e;
  integer      dv [6] = '{4096, 1, 8, 64, 256, 1024};
  integer      fm [4] = '{3, 2, 1, 1};
  logic [7:0]  cbt [8] = '{8'h40, 8'h40, 8'h00, 8'h00,
                           8'h58, 8'h10, 8'h50, 8'h00};
  logic [1:0]  wlt [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0};
  logic [7:0]  ex = 8'b1000_1001;

  sbt_timer dut_u (.mclk(mclk), .rst(rst), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .io_rdata_r(rdata),
    .waveform_mode_low(wlow), .compare_output_mode_a(coma),
    .compare_output_mode_b(comb), .compare_output_mode_c(comc),
    .compare_value_b(cmpb), .compare_value_c(cmpc),
    .capture_interrupt_enable(cie), .global_irq_enable(gie),
    .capture_flag_clear(fclr), .capture_input_pin(cpin),
    .external_count_pin(epin), .capture_value_r(capv),
    .capture_event_flag_r(flag), .capture_irq_r(irq),
    .compare_a_match_r(mta), .compare_output_a(oa), .compare_output_b(ob),
    .compare_output_c(oc), .compare_output_a_en(oae),
    .compare_output_b_en(obe), .compare_output_c_en(oce));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task chk(input string n, input logic [15:0] s, input logic [15:0] x);
    checked = checked + 1;
    if (s !== x) begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  // requests start just after an edge and hold through the taking edge;
  // the strobe drops only when the next task or wait takes over, so
  // back-to-back calls never assign it twice in one time step
  task wr(input logic [7:0] a, input logic [7:0] d);
    io_re = 1'b0;
    io_addr = a;
    io_wdata = d;
    io_we = 1'b1;
    @(posedge mclk);
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    io_we = 1'b0;
    io_addr = a;
    io_re = 1'b1;
    @(posedge mclk);
    #1 d = rdata;
  endtask
  task cw(input integer n);
    io_we = 1'b0;
    io_re = 1'b0;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // high byte goes to the shared latch, low byte commits both
  task cnt_set(input logic [15:0] x);
    wr(`SBT_OFS_CNT_HIGH, x[15:8]);
    wr(`SBT_OFS_CNT_LOW, x[7:0]);
  endtask
  task cnt_get(output logic [15:0] x);
    rd(`SBT_OFS_CNT_LOW, x[7:0]);
    rd(`SBT_OFS_CNT_HIGH, x[15:8]);
  endtask
  task print_verdict;
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // match pulses, output edges and the hang limit
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (mta === 1'b1) nmatch = nmatch + 1;
    if (cyc == 40000) begin
      failures = failures + 1;
      print_verdict;
    end
  end
  always @(oa) ntog = ntog + 1;

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {io_we, io_re, cie, gie, fclr, cpin, epin} = 7'h00;
    {io_addr, io_wdata, wlow, coma, comb, comc} = 22'h0;
    {cmpb, cmpc} = 32'h0;
    {failures, checked, cyc, nmatch, ntog} = 0;
    seed = 32'h21FC99D9;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    rd(`SBT_OFS_CTRL_B, b);
    chk("ctrl b reset", b, `SBT_RST_CTRL_B);
    wr(`SBT_OFS_CTRL_B, 8'hF8);
    rd(`SBT_OFS_CTRL_B, b);
    chk("ctrl b", b, 8'hD8);
    wr(`SBT_OFS_CTRL_C, 8'hFF);
    rd(`SBT_OFS_CTRL_C, b);
    chk("ctrl c", b, 8'h00);
    rd(8'h93, b);
    chk("unmapped", b, 8'h00);
    wr(`SBT_OFS_CTRL_B, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      cnt_set(v);
      cnt_get(r);
      chk("counter rw", r, v);
    end
    // a window of 2048 edges holds an exact number of prescaled ticks
    for (i = 0; i < 6; i = i + 1) begin
      cnt_set(16'h0000);
      wr(`SBT_OFS_CTRL_B, i[7:0]);
      cw(2047);
      wr(`SBT_OFS_CTRL_B, 8'h00);
      cnt_get(r);
      chk("prescaled count", r, 2048 / dv[i]);
    end
    for (i = 6; i < 8; i = i + 1) begin
      cnt_set(16'h0000);
      wr(`SBT_OFS_CTRL_B, i[7:0]);
      repeat (5) begin
        epin = 1'b1;
        cw(4);
        epin = 1'b0;
        cw(4);
      end
      cw(8);
      wr(`SBT_OFS_CTRL_B, 8'h00);
      cnt_get(r);
      chk("external count", r, 16'h0005);
    end
    e = 0;
    for (i = 0; i < 4; i = i + 1) begin
      {coma, comb, comc} = {3{fm[i][1:0]}};
      j = nmatch;
      wr(`SBT_OFS_CTRL_C, 8'hE0);
      cw(1);
      e = (fm[i] == 3) ? 1 : (fm[i] == 2) ? 0 : 1 - e;
      chk("forced outputs", {oa, ob, oc}, {3{e[0]}});
      chk("forced no match", nmatch - j, 0);
      chk("output enables", {oae, obe, oce}, 3'h7);
    end
    wlow = 2'h1;
    wr(`SBT_OFS_CTRL_B, 8'h08);
    cw(2);
    o = {oa, ob, oc};
    wr(`SBT_OFS_CTRL_C, 8'hE0);
    cw(2);
    chk("pwm force", {oa, ob, oc}, o);
    chk("pwm enables", {oae, obe, oce}, 3'h0);
    wlow = 2'h0;
    wr(`SBT_OFS_CMPA_HIGH, 8'h00);
    wr(`SBT_OFS_CMPA_LOW, 8'h05);
    // clear on match gives one match every six ticks
    for (i = 0; i < 2; i = i + 1) begin
      wr(`SBT_OFS_CTRL_B, 8'h00);
      cnt_set(16'h0000);
      wr(`SBT_OFS_CTRL_B, i ? 8'h19 : 8'h09);
      cw(20);
      j = nmatch;
      e = ntog;
      cw(60);
      chk("clear on match", nmatch - j, 16'h000A);
      chk("toggles", ntog - e, 16'h000A);
    end
    wr(`SBT_OFS_CTRL_B, 8'h00);
    cnt_set(16'h0005);
    j = nmatch;
    wr(`SBT_OFS_CTRL_B, 8'h01);
    cw(10);
    chk("blocked match", nmatch - j, 0);
    wr(`SBT_OFS_CTRL_B, 8'h00);
    // phase correct 8-bit: climbs to the maximum, then turns back down
    wlow = 2'h1;
    cnt_set(16'h00FD);
    wr(`SBT_OFS_CTRL_B, 8'h01);
    cw(9);
    wr(`SBT_OFS_CTRL_B, 8'h00);
    wlow = 2'h0;
    cnt_get(r);
    chk("phase correct", r, 16'h00F7);
    {cie, gie} = 2'b11;
    v = $random(seed);
    cnt_set(v);
    // edge polarity and disconnect table, pin toggles each step
    for (i = 0; i < 8; i = i + 1) begin
      fclr = 1'b1;
      cw(1);
      fclr = 1'b0;
      wlow = wlt[i];
      wr(`SBT_OFS_CTRL_B, cbt[i]);
      cpin = ~cpin;
      cw(20);
      chk("capture flag", flag, ex[i]);
      chk("capture request", irq, ex[i]);
      if (ex[i]) chk("capture value", capv, v);
    end
    fclr = 1'b1;
    cw(1);
    fclr = 1'b0;
    wr(`SBT_OFS_CTRL_B, 8'hC0);
    cpin = 1'b1;
    cw(2);
    cpin = 1'b0;
    cw(20);
    chk("filtered glitch", flag, 1'b0);
    cpin = 1'b1;
    cw(20);
    chk("filtered edge", flag, 1'b1);
    print_verdict;
  end
endmodule
`default_nettype wire
